/* hdl/brf_pkg.sv */
// Purpose: shared constants for the banked data register file
// Assumes: 8-bit core, 5-bit direct file address, 7-bit indirect pointer
// Notes: reset values are plain defaults; the core may overwrite them
package brf_pkg;
   // ------------------------------------------------------------------
   // widths and map
   // ------------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int ADDR_W = 5;
   localparam int SFR_COUNT = 7;
   localparam int GPR_BASE = 25;
   localparam int GPR_BANKED = 16;
   localparam int IDX_W = 6;
   localparam int SYNC_STAGES = 3;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [4:0] OFF_INDIRECT_DATA_PORT = 5'h00;
   localparam logic [4:0] OFF_TIMER_COUNT = 5'h01;
   localparam logic [4:0] OFF_PROGRAM_COUNTER_LOW = 5'h02;
   localparam logic [4:0] OFF_STATUS_FLAGS = 5'h03;
   localparam logic [4:0] OFF_INDIRECT_POINTER = 5'h04;
   localparam logic [4:0] OFF_OSC_TRIM = 5'h05;
   localparam logic [4:0] OFF_IO_PORT_PINS = 5'h06;
   localparam logic [4:0] OFF_GPR_LOW = 5'h07;
   localparam logic [4:0] OFF_GPR_HIGH = 5'h10;
   localparam logic [5:0] IDX_BANK1 = 6'h19;

   // ------------------------------------------------------------------
   // fields
   // ------------------------------------------------------------------
   localparam int BANK_BIT = 5;
   localparam int ZERO_BIT = 2;
   localparam int DIGIT_CARRY_BIT = 1;
   localparam int CARRY_BIT = 0;
   // time-out and power-down bits are not writable by software
   localparam logic [7:0] STATUS_WR_MASK = 8'he7;
   localparam logic [7:0] FLAG_MASK = 8'h07;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_TIMER = 8'h00;
   localparam logic [7:0] RST_PCL = 8'hff;
   localparam logic [7:0] RST_STATUS = 8'h18;
   localparam logic [7:0] RST_POINTER = 8'h00;
   localparam logic [7:0] RST_TRIM = 8'h00;
   localparam logic [7:0] RST_PORT = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hff;
   localparam logic [7:0] RST_OPTION = 8'hff;
   localparam logic [7:0] ONE_BYTE = 8'h01;
endpackage

/* hdl/brf_register_file.sv */
// Purpose: byte-wide data memory of a small 8-bit core, with banking
// Assumes: one access per cycle from the execution unit, same clock
// Notes: reads return data on the edge after RD_EN; writes land at once
`timescale 1ns/1ps

// How it works
// - data memory is a byte register file: special and general registers
// - special group: timer, program counter low, status, pointer, trim, port
// - extra direction and prescaler option registers, written by strobe
// - small variant: seven special and twenty-five general registers
// - large variant adds sixteen general registers via bank select
// - general registers reachable directly or through the pointer
module brf_register_file import brf_pkg::*; #(
   parameter int BANKED = 1
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // file access from the execution unit
   input wire logic [ADDR_W-1:0] FILE_ADDR,
   input wire logic RD_EN,
   input wire logic WR_EN,
   input wire logic [DATA_W-1:0] WR_DATA,
   output logic [DATA_W-1:0] RD_DATA,
   // core side updates
   input wire logic TIMER_INC,
   input wire logic PC_LOAD,
   input wire logic [DATA_W-1:0] PC_IN,
   input wire logic FLAG_WE,
   input wire logic [2:0] FLAG_IN,
   input wire logic DIR_WE,
   input wire logic OPTION_WE,
   // register views
   output logic [DATA_W-1:0] TIMER_COUNT,
   output logic [DATA_W-1:0] PC_LOW,
   output logic [DATA_W-1:0] STATUS_FLAGS,
   output logic [DATA_W-1:0] INDIRECT_POINTER,
   output logic [DATA_W-1:0] OSC_TRIM,
   output logic [DATA_W-1:0] OPTION_BITS,
   // port pins
   input wire logic [DATA_W-1:0] IO_PIN_IN,
   output logic [DATA_W-1:0] IO_PIN_OUT,
   output logic [DATA_W-1:0] IO_PIN_OE_N
);
   // ------------------------------------------------------------------
   // parameter check
   // ------------------------------------------------------------------
   localparam int GPR_DEPTH = GPR_BASE + (BANKED != 0 ? GPR_BANKED : 0);
   if (BANKED != 0 && BANKED != 1) begin : g_bad_banked
      $error("BANKED must be 0 or 1");
   end

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   logic [6:0] eff_addr;
   logic [4:0] low_addr;
   logic bank_sel;
   logic is_virtual;
   logic gpr_hit;
   logic [IDX_W-1:0] gpr_idx;
   logic [DATA_W-1:0] pointer_q;

   always_comb begin
      // address 0 reaches through the pointer
      eff_addr = (FILE_ADDR == OFF_INDIRECT_DATA_PORT) ? pointer_q[6:0]
                 : {pointer_q[6:5], FILE_ADDR};
      low_addr = eff_addr[4:0];
      // small variant ignores the bank bit, so both banks alias
      bank_sel = (BANKED != 0) && eff_addr[BANK_BIT];
      // pointer aimed at the port itself reads zero
      is_virtual = (low_addr == OFF_INDIRECT_DATA_PORT);
      gpr_hit = (low_addr >= OFF_GPR_LOW);
      if (bank_sel && low_addr >= OFF_GPR_HIGH) begin
         gpr_idx = IDX_BANK1 + IDX_W'(low_addr - OFF_GPR_HIGH);
      end else begin
         gpr_idx = IDX_W'(low_addr - OFF_GPR_LOW);
      end
   end

   // ------------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] sync1_q, sync2_q, sync3_q, pin_q, pin_d;

   always_comb begin
      // a change counts only once the last two stages agree
      pin_d = pin_q;
      for (int b = 0; b < DATA_W; b++) begin
         if (sync2_q[b] == sync3_q[b]) begin
            pin_d[b] = sync3_q[b];
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         sync1_q <= RST_PORT;
         sync2_q <= RST_PORT;
         sync3_q <= RST_PORT;
         pin_q <= RST_PORT;
      end else begin
         sync1_q <= IO_PIN_IN;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pin_q <= pin_d;
      end
   end

   // ------------------------------------------------------------------
   // general purpose storage
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] gpr_mem [GPR_DEPTH];
   logic gpr_wr;

   assign gpr_wr = WR_EN && gpr_hit && !is_virtual;

   // storage has no reset; contents are unknown until first written
   always_ff @(posedge MCLK) begin
      if (gpr_wr) begin
         gpr_mem[gpr_idx] <= WR_DATA;
      end
   end

   // ------------------------------------------------------------------
   // special function registers
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] timer_q, timer_d, pcl_q, pcl_d, status_q, status_d;
   logic [DATA_W-1:0] pointer_d, trim_q, trim_d, port_q, port_d;
   logic [DATA_W-1:0] dir_q, dir_d, option_q, option_d, rd_q, rd_d;
   logic sfr_wr;

   assign sfr_wr = WR_EN && !gpr_hit && !is_virtual;

   always_comb begin
      timer_d = timer_q;
      pcl_d = pcl_q;
      status_d = status_q;
      pointer_d = pointer_q;
      trim_d = trim_q;
      port_d = port_q;
      dir_d = dir_q;
      option_d = option_q;
      rd_d = rd_q;
      // core side updates first; a file write overrides them
      if (TIMER_INC) begin
         timer_d = timer_q + ONE_BYTE;
      end
      if (PC_LOAD) begin
         pcl_d = PC_IN;
      end
      if (FLAG_WE) begin
         status_d = (status_q & ~FLAG_MASK) | {5'h00, FLAG_IN};
      end
      if (DIR_WE) begin
         dir_d = WR_DATA;
      end
      if (OPTION_WE) begin
         option_d = WR_DATA;
      end
      if (sfr_wr) begin
         case (low_addr)
            OFF_TIMER_COUNT: timer_d = WR_DATA;
            OFF_PROGRAM_COUNTER_LOW: pcl_d = WR_DATA;
            OFF_STATUS_FLAGS: begin
               status_d = (status_q & ~STATUS_WR_MASK)
                          | (WR_DATA & STATUS_WR_MASK);
            end
            OFF_INDIRECT_POINTER: pointer_d = WR_DATA;
            OFF_OSC_TRIM: trim_d = WR_DATA;
            OFF_IO_PORT_PINS: port_d = WR_DATA;
            default: ;
         endcase
      end
      if (RD_EN) begin
         if (is_virtual) begin
            rd_d = '0;
         end else if (gpr_hit) begin
            rd_d = gpr_mem[gpr_idx];
         end else begin
            case (low_addr)
               OFF_TIMER_COUNT: rd_d = timer_q;
               OFF_PROGRAM_COUNTER_LOW: rd_d = pcl_q;
               OFF_STATUS_FLAGS: rd_d = status_q;
               OFF_INDIRECT_POINTER: rd_d = pointer_q;
               OFF_OSC_TRIM: rd_d = trim_q;
               // port reads show the pins, not the latch
               OFF_IO_PORT_PINS: rd_d = pin_q;
               default: rd_d = '0;
            endcase
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         timer_q <= RST_TIMER;
         pcl_q <= RST_PCL;
         status_q <= RST_STATUS;
         pointer_q <= RST_POINTER;
         trim_q <= RST_TRIM;
         port_q <= RST_PORT;
         dir_q <= RST_DIR;
         option_q <= RST_OPTION;
         rd_q <= '0;
      end else begin
         timer_q <= timer_d;
         pcl_q <= pcl_d;
         status_q <= status_d;
         pointer_q <= pointer_d;
         trim_q <= trim_d;
         port_q <= port_d;
         dir_q <= dir_d;
         option_q <= option_d;
         rd_q <= rd_d;
      end
   end

   assign RD_DATA = rd_q;
   assign TIMER_COUNT = timer_q;
   assign PC_LOW = pcl_q;
   assign STATUS_FLAGS = status_q;
   assign INDIRECT_POINTER = pointer_q;
   assign OSC_TRIM = trim_q;
   assign OPTION_BITS = option_q;
   assign IO_PIN_OUT = port_q;
   // direction bit 1 means input, so it doubles as the active-low enable
   assign IO_PIN_OE_N = dir_q;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   AST_INDIRECT_ZERO: assert property (
      RD_EN && is_virtual |=> RD_DATA == '0)
      else $error("virtual port read not zero");
   AST_TIMER_READ: assert property (
      RD_EN && !is_virtual && low_addr == OFF_TIMER_COUNT
      |=> RD_DATA == $past(timer_q))
      else $error("timer read mismatch");
   AST_POINTER_WRITE: assert property (
      WR_EN && !is_virtual && low_addr == OFF_INDIRECT_POINTER
      |=> INDIRECT_POINTER == $past(WR_DATA))
      else $error("pointer write lost");
   AST_TIMER_INC: assert property (
      TIMER_INC && !(sfr_wr && low_addr == OFF_TIMER_COUNT)
      |=> TIMER_COUNT == $past(TIMER_COUNT) + ONE_BYTE)
      else $error("timer did not advance");
   AST_STATUS_RO: assert property (
      sfr_wr && low_addr == OFF_STATUS_FLAGS
      |=> STATUS_FLAGS[4:3] == $past(STATUS_FLAGS[4:3]))
      else $error("status read-only bits changed");
   AST_ALIAS_LOW: assert property (
      gpr_hit && low_addr < OFF_GPR_HIGH
      |-> gpr_idx + IDX_W'(OFF_GPR_LOW) == IDX_W'(low_addr))
      else $error("low half not aliased");
   AST_BANK1_DISTINCT: assert property (
      bank_sel && low_addr >= OFF_GPR_HIGH |-> gpr_idx >= IDX_BANK1)
      else $error("bank 1 high half not distinct");
   AST_SMALL_RANGE: assert property (
      gpr_hit && !is_virtual |-> int'(gpr_idx) < GPR_DEPTH)
      else $error("general register index out of range");
   AST_OPTION_WRITE: assert property (
      OPTION_WE |=> OPTION_BITS == $past(WR_DATA))
      else $error("option write lost");
   AST_PIN_SYNC: assert property (
      sync2_q == sync3_q |=> pin_q == $past(sync3_q))
      else $error("pin sample not taken");

   COV_INDIRECT_READ: cover property (
      RD_EN && FILE_ADDR == OFF_INDIRECT_DATA_PORT && gpr_hit);
   COV_BANK1_WRITE: cover property (gpr_wr && gpr_idx >= IDX_BANK1);
   COV_TIMER_CLASH: cover property (
      TIMER_INC && sfr_wr && low_addr == OFF_TIMER_COUNT);
endmodule // brf_register_file

/* tb/brf_core_model.sv */
// Purpose: execution unit model driving the file bus and core strobes
// Assumes: inputs change just after a rising MCLK edge
// Notes: pins model the wire: latch where driven, pin_drv elsewhere
`timescale 1ns/1ps
module brf_core_model import brf_pkg::*; (
   // clock
   input wire logic MCLK,
   // file bus
   output logic [ADDR_W-1:0] FILE_ADDR,
   output logic RD_EN,
   output logic WR_EN,
   output logic [DATA_W-1:0] WR_DATA,
   input wire logic [DATA_W-1:0] RD_DATA,
   // core strobes
   output logic TIMER_INC,
   output logic PC_LOAD,
   output logic [DATA_W-1:0] PC_IN,
   output logic FLAG_WE,
   output logic [2:0] FLAG_IN,
   output logic DIR_WE,
   output logic OPTION_WE,
   // pins
   input wire logic [DATA_W-1:0] IO_PIN_OUT,
   input wire logic [DATA_W-1:0] IO_PIN_OE_N,
   output logic [DATA_W-1:0] IO_PIN_IN
);
   logic [DATA_W-1:0] pin_drv;
   assign IO_PIN_IN = (IO_PIN_OUT & ~IO_PIN_OE_N) | (pin_drv & IO_PIN_OE_N);
   initial begin
      {FILE_ADDR, RD_EN, WR_EN, WR_DATA, PC_IN, FLAG_IN} = '0;
      {TIMER_INC, PC_LOAD, FLAG_WE, DIR_WE, OPTION_WE} = '0;
      pin_drv = 8'h00;
   end
   // address 0 goes through the pointer
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge MCLK);
      FILE_ADDR <= a;
      WR_DATA <= d;
      WR_EN <= 1'b1;
      @(posedge MCLK);
      WR_EN <= 1'b0;
      #1;
   endtask
   // file write with a timer tick in the same cycle: the write wins
   task automatic wr_tick(input logic [4:0] a, input logic [7:0] d);
      @(posedge MCLK);
      FILE_ADDR <= a;
      WR_DATA <= d;
      WR_EN <= 1'b1;
      TIMER_INC <= 1'b1;
      @(posedge MCLK);
      WR_EN <= 1'b0;
      TIMER_INC <= 1'b0;
      #1;
   endtask
   // level seen on pins that the block does not drive
   task automatic drive_pins(input logic [7:0] v);
      pin_drv <= v;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge MCLK);
      FILE_ADDR <= a;
      RD_EN <= 1'b1;
      @(posedge MCLK);
      RD_EN <= 1'b0;
      @(posedge MCLK);
      #1 d = RD_DATA;
   endtask
   // s = {timer, pc, flags, dir, option}; d feeds every data input
   task automatic strb(input logic [4:0] s, input logic [7:0] d);
      @(posedge MCLK);
      {TIMER_INC, PC_LOAD, FLAG_WE, DIR_WE, OPTION_WE} <= s;
      {WR_DATA, PC_IN, FLAG_IN} <= {d, d, d[2:0]};
      @(posedge MCLK);
      {TIMER_INC, PC_LOAD, FLAG_WE, DIR_WE, OPTION_WE} <= 5'h00;
      #1;
   endtask
endmodule // brf_core_model

/* tb/banked_data_register_file_test.sv */
// Purpose: self-checking bench for the banked register file
// Assumes: large variant, reset held four cycles
// Notes: expectations come from the map, never from the design
`timescale 1ns/1ps
module banked_data_register_file_test import brf_pkg::*;;
   logic MCLK, RESET_N;
   int num_errors = 0, samples_checked = 0;
   logic [4:0] fa;
   logic rd_en, wr_en, t_inc, pc_ld, f_we, d_we, o_we;
   logic [7:0] wd, rdat, pc_in, tmr, program_counter_low, sts, ptr, trim, opt, po, poe, pin;
   logic [2:0] f_in;
   logic [7:0] i;
   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   brf_core_model u_core (.MCLK(MCLK), .FILE_ADDR(fa), .RD_EN(rd_en),
      .WR_EN(wr_en), .WR_DATA(wd), .RD_DATA(rdat), .TIMER_INC(t_inc),
      .PC_LOAD(pc_ld), .PC_IN(pc_in), .FLAG_WE(f_we), .FLAG_IN(f_in),
      .DIR_WE(d_we), .OPTION_WE(o_we), .IO_PIN_OUT(po),
      .IO_PIN_OE_N(poe), .IO_PIN_IN(pin));
   brf_register_file #(.BANKED(1)) u_dut (.MCLK(MCLK), .RESET_N(RESET_N),
      .FILE_ADDR(fa), .RD_EN(rd_en), .WR_EN(wr_en), .WR_DATA(wd),
      .RD_DATA(rdat), .TIMER_INC(t_inc), .PC_LOAD(pc_ld), .PC_IN(pc_in),
      .FLAG_WE(f_we), .FLAG_IN(f_in), .DIR_WE(d_we), .OPTION_WE(o_we),
      .TIMER_COUNT(tmr), .PC_LOW(program_counter_low), .STATUS_FLAGS(sts),
      .INDIRECT_POINTER(ptr), .OSC_TRIM(trim), .OPTION_BITS(opt),
      .IO_PIN_IN(pin), .IO_PIN_OUT(po), .IO_PIN_OE_N(poe));
   task automatic wrap_up();
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_core.rd(a, d);
      chk(d, exp);
   endtask
   // hang guard
   initial begin
      repeat (5000) @(posedge MCLK);
      num_errors++;
      wrap_up();
   end
   initial begin
      RESET_N = 1'b0;
      repeat (4) @(posedge MCLK);
      RESET_N <= 1'b1;
      @(posedge MCLK);
      chk({tmr, program_counter_low, sts, ptr, trim, opt, po, poe}, 64'h00ff180000ff00ff);
      chk(rdat, 8'h00);
      u_core.wr(5'h05, 8'ha5);
      rchk(5'h05, 8'ha5);
      chk(trim, 8'ha5);
      u_core.wr(5'h06, 8'h3c);
      chk(po, 8'h3c);
      u_core.wr(5'h02, 8'h44);
      chk(program_counter_low, 8'h44);
      // status bits 4:3 must survive file writes
      u_core.wr(5'h03, 8'hff);
      rchk(5'h03, 8'hff);
      u_core.wr(5'h03, 8'h00);
      rchk(5'h03, 8'h18);
      u_core.wr(5'h04, 8'h0a);
      u_core.wr(5'h00, 8'h77);
      rchk(5'h0a, 8'h77);
      rchk(5'h00, 8'h77);
      chk(ptr, 8'h0a);
      u_core.wr(5'h04, 8'h00);
      u_core.wr(5'h00, 8'h55);
      rchk(5'h00, 8'h00);
      for (i = 8'h07; i <= 8'h1f; i++) begin
         u_core.wr(i[4:0], i ^ 8'h5a);
      end
      for (i = 8'h07; i <= 8'h1f; i++) rchk(i[4:0], i ^ 8'h5a);
      u_core.wr(5'h04, 8'h20);
      rchk(5'h00, 8'h00);
      for (i = 8'h10; i <= 8'h1f; i++) begin
         u_core.wr(i[4:0], i ^ 8'hc3);
      end
      for (i = 8'h10; i <= 8'h1f; i++) rchk(i[4:0], i ^ 8'hc3);
      for (i = 8'h07; i <= 8'h0f; i++) rchk(i[4:0], i ^ 8'h5a);
      u_core.wr(5'h04, 8'h35);
      rchk(5'h00, 8'h15 ^ 8'hc3);
      u_core.wr(5'h04, 8'h00);
      for (i = 8'h10; i <= 8'h1f; i++) rchk(i[4:0], i ^ 8'h5a);
      u_core.wr(5'h01, 8'h10);
      u_core.strb(5'h10, 8'h00);
      chk(tmr, 8'h11);
      // a file write beats a tick in the same cycle
      u_core.wr_tick(5'h01, 8'h80);
      chk(tmr, 8'h80);
      u_core.strb(5'h08, 8'h5c);
      chk(program_counter_low, 8'h5c);
      u_core.strb(5'h04, 8'h05);
      rchk(5'h03, 8'h1d);
      u_core.strb(5'h02, 8'h0f);
      chk(poe, 8'h0f);
      u_core.strb(5'h01, 8'h3a);
      chk(opt, 8'h3a);
      // low nibble is input now, high nibble driven by the latch
      u_core.drive_pins(8'h09);
      repeat (6) @(posedge MCLK);
      rchk(5'h06, 8'h39);
      wrap_up();
   end
endmodule // banked_data_register_file_test
